// ==== src/ttc_pkg.sv ====
// Purpose: constants for the transaction timer control and status registers
// Assumes: 32-bit APB, msb-first bit numbering (bit 0 is data[31])
// Notes: bit n of the documented numbering sits at data[31-n]
package ttc_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] TTC_OFS_CTRL = 8'h60;
   localparam logic [7:0] TTC_OFS_STAT1 = 8'h64;
   localparam logic [7:0] TTC_OFS_STAT2 = 8'h68;
   localparam logic [7:0] TTC_OFS_STAT3 = 8'h6C;
   // -------------------------------------------------------------
   // field positions (data bit index, msb-first numbering folded in)
   // -------------------------------------------------------------
   localparam int TTC_NSRC = 7;
   localparam int TTC_POS_DONE = 31;
   localparam int TTC_POS_ERR = 23;
   localparam int TTC_POS_RTRY = 15;
   localparam int TTC_POS_SEL = 4;
   localparam int TTC_POS_ABORT = 3;
   localparam int TTC_POS_HOLD = 2;
   localparam int TTC_POS_REL = 1;
   // sources by documented slot: 0 dtf,1 drf,2 atf,3 mtq,4 ctq,5 none,6 ar
   localparam logic [6:0] TTC_VALID_SRC = 7'h5F;
   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [31:0] TTC_CTRL_RESET = 32'hFA000000;
   localparam logic [6:0] TTC_DONE_RESET = 7'h5F;
   localparam logic [3:0] TTC_SEL_RESET = 4'h0;
   localparam logic [31:0] TTC_STAT_RESET = 32'h00000000;
   // timer select codes
   localparam logic [3:0] TTC_SEL_DTF = 4'h0;
   localparam logic [3:0] TTC_SEL_DRF = 4'h1;
   localparam logic [3:0] TTC_SEL_MTQ = 4'h2;
   localparam logic [3:0] TTC_SEL_CTQ = 4'h4;
   localparam logic [3:0] TTC_SEL_AR = 4'h6;
endpackage

// ==== src/ttc_regs.sv ====
// Purpose: transaction timer control register and selected-timer status view
// Assumes: APB slave, zero wait states; engine events are single-cycle pulses
// Notes: per-timer request details are latched here on each transaction start
`timescale 1ns/100ps
// Contract
// - error flags of sources set on errored end, cleared on clean end or start
// - error flags of slots 0 and 1 survive bus reset; done flags set, other flags and controls cleared
// - retry flag sets when source starts retrying after busy acknowledge
// - retry flag clears on retry end or bus reset
// - timer select field picks target of abort, hold and status view
// - select codes 0,1,2,4,6 map to sources; all other codes reserved
// - timer select is zero after power-on and after every bus reset
// - abort control aborts selected transaction, then clears itself
// - aborting the data transmit fifo transaction sets its error flag
// - hold control suspends transmission of the selected timer
// - hold and release written together: hold ignored, transaction aborted
// - release control restarts suspended transmission and clears itself
// - status registers zero at power-on and bus reset, show selected timer
// - status one: node id in bits 0-15, offset upper in 16-31
// - done flags clear on start, set on completion, one after bus reset
// - data transmit error flag set on error or abort, kept on bus reset
// - control register powers up FA000000; bus reset restores it except the slot 0 and 1 error flags
module ttc_regs #(
   parameter int NSRC = ttc_pkg::TTC_NSRC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // link layer events, one bit per source slot except bus reset
   input wire logic bus_reset_i,
   input wire logic [NSRC-1:0] tx_start_i,
   input wire logic [NSRC-1:0] tx_end_ok_i,
   input wire logic [NSRC-1:0] tx_end_err_i,
   input wire logic [NSRC-1:0] retry_start_i,
   input wire logic [NSRC-1:0] retry_end_i,
   input wire logic [NSRC-1:0] abort_done_i,
   input wire logic [NSRC-1:0] release_done_i,
   // request details captured on tx_start_i
   input wire logic [15:0] req_node_id_i,
   input wire logic [15:0] req_offset_upper_i,
   input wire logic [31:0] req_offset_low_i,
   input wire logic [31:0] req_info_i,
   // controls toward transmit engine
   output logic [NSRC-1:0] abort_req_o,
   output logic [NSRC-1:0] hold_o,
   output logic [NSRC-1:0] release_req_o
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // select codes 0,1,4,6 map to their own slot, code 2 to slot 3; reserved codes select nothing
   function automatic logic [NSRC-1:0] sel_onehot(input logic [3:0] sel);
      logic [NSRC-1:0] v;
      v = '0;
      unique case (sel)
         ttc_pkg::TTC_SEL_DTF: v[0] = 1'b1;
         ttc_pkg::TTC_SEL_DRF: v[1] = 1'b1;
         ttc_pkg::TTC_SEL_MTQ: v[3] = 1'b1;
         ttc_pkg::TTC_SEL_CTQ: v[4] = 1'b1;
         ttc_pkg::TTC_SEL_AR: v[6] = 1'b1;
         default: v = '0;
      endcase
      return v;
   endfunction

   // ---------------------------------------------------------------
   // bus access
   // ---------------------------------------------------------------
   logic acc;
   logic wr_ctrl;
   assign acc = psel_i && penable_i;
   assign wr_ctrl = acc && pwrite_i && (paddr_i == ttc_pkg::TTC_OFS_CTRL);
   assign pready_o = 1'b1;

   logic [3:0] sel_r;
   logic [NSRC-1:0] sel_vec;
   logic [NSRC-1:0] wsel_vec;
   logic w_abort;
   logic w_hold;
   logic w_rel;
   assign sel_vec = sel_onehot(sel_r);
   // a write that also changes select acts on the newly written timer
   assign wsel_vec = sel_onehot(pwdata_i[ttc_pkg::TTC_POS_SEL +: 4]);
   assign w_abort = wr_ctrl && (pwdata_i[ttc_pkg::TTC_POS_ABORT] ||
      (pwdata_i[ttc_pkg::TTC_POS_HOLD] && pwdata_i[ttc_pkg::TTC_POS_REL]));
   assign w_hold = wr_ctrl && pwdata_i[ttc_pkg::TTC_POS_HOLD] &&
      !pwdata_i[ttc_pkg::TTC_POS_REL];
   assign w_rel = wr_ctrl && pwdata_i[ttc_pkg::TTC_POS_REL] &&
      !pwdata_i[ttc_pkg::TTC_POS_HOLD];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_r <= ttc_pkg::TTC_SEL_RESET;
      end else if (bus_reset_i) begin
         sel_r <= ttc_pkg::TTC_SEL_RESET;
      end else if (wr_ctrl) begin
         sel_r <= pwdata_i[ttc_pkg::TTC_POS_SEL +: 4];
      end
   end

   // ---------------------------------------------------------------
   // self-clearing abort and release controls, level hold control
   // ---------------------------------------------------------------
   logic [NSRC-1:0] abort_r;
   logic [NSRC-1:0] hold_r;
   logic [NSRC-1:0] rel_r;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         abort_r <= '0;
      end else if (bus_reset_i) begin
         abort_r <= '0;
      end else begin
         // new request wins over a completion in the same cycle
         abort_r <= (abort_r & ~abort_done_i) | (w_abort ? wsel_vec : '0);
      end
   end

   // hold lasts until release or abort; release resumes the held source
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hold_r <= '0;
      end else if (bus_reset_i) begin
         hold_r <= '0;
      end else begin
         hold_r <= (hold_r & ~(w_rel ? wsel_vec : '0) & ~(w_abort ? wsel_vec : '0))
            | (w_hold ? wsel_vec : '0);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rel_r <= '0;
      end else if (bus_reset_i) begin
         rel_r <= '0;
      end else begin
         rel_r <= (rel_r & ~release_done_i) | (w_rel ? wsel_vec : '0);
      end
   end

   assign abort_req_o = abort_r;
   assign hold_o = hold_r;
   assign release_req_o = rel_r;

   // ---------------------------------------------------------------
   // per-source flags
   // ---------------------------------------------------------------
   logic [NSRC-1:0] done_f;
   logic [NSRC-1:0] err_f;
   logic [NSRC-1:0] rtry_f;

   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         if (ttc_pkg::TTC_VALID_SRC[g]) begin : g_on
            ttc_src_flags #(
               .ERR_KEEP_ON_BUS_RESET((g == 0) || (g == 1))
            ) u_flags (
               .clk_i(clk_i),
               .rst_b_i(rst_b_i),
               .bus_reset_i(bus_reset_i),
               .start_i(tx_start_i[g]),
               .end_ok_i(tx_end_ok_i[g]),
               .end_err_i(tx_end_err_i[g]),
               .abort_i(abort_done_i[g] && abort_r[g] && (g == 0)),
               .retry_start_i(retry_start_i[g]),
               .retry_end_i(retry_end_i[g]),
               .done_o(done_f[g]),
               .err_o(err_f[g]),
               .retry_o(rtry_f[g])
            );
         end else begin : g_off
            assign done_f[g] = 1'b0;
            assign err_f[g] = 1'b0;
            assign rtry_f[g] = 1'b0;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // per-timer request details
   // ---------------------------------------------------------------
   logic [31:0] st1_r [NSRC];
   logic [31:0] st2_r [NSRC];
   logic [31:0] st3_r [NSRC];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NSRC; i++) begin
            st1_r[i] <= ttc_pkg::TTC_STAT_RESET;
            st2_r[i] <= ttc_pkg::TTC_STAT_RESET;
            st3_r[i] <= ttc_pkg::TTC_STAT_RESET;
         end
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            if (bus_reset_i) begin
               st1_r[i] <= ttc_pkg::TTC_STAT_RESET;
               st2_r[i] <= ttc_pkg::TTC_STAT_RESET;
               st3_r[i] <= ttc_pkg::TTC_STAT_RESET;
            end else if (tx_start_i[i]) begin
               // msb-first: node id is bits 0-15, i.e. data[31:16]
               st1_r[i] <= {req_node_id_i, req_offset_upper_i};
               st2_r[i] <= req_offset_low_i;
               st3_r[i] <= req_info_i;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   function automatic logic [31:0] pick(input logic [31:0] arr [NSRC],
                                        input logic [NSRC-1:0] onehot);
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (onehot[i]) begin
            v = arr[i];
         end
      end
      return v;
   endfunction

   logic [31:0] ctrl_view;
   logic [31:0] rd_nxt;
   logic [31:0] rd_r;
   logic err_nxt;
   logic err_r;

   always_comb begin
      ctrl_view = '0;
      for (int i = 0; i < NSRC; i++) begin
         // slot i maps to documented bit i of each flag group: data[31-i], data[23-i], data[15-i]
         ctrl_view[ttc_pkg::TTC_POS_DONE - i] = done_f[i];
         ctrl_view[ttc_pkg::TTC_POS_ERR - i] = err_f[i];
         ctrl_view[ttc_pkg::TTC_POS_RTRY - i] = rtry_f[i];
      end
      ctrl_view[ttc_pkg::TTC_POS_SEL +: 4] = sel_r;
      ctrl_view[ttc_pkg::TTC_POS_ABORT] = |(abort_r & sel_vec);
      ctrl_view[ttc_pkg::TTC_POS_HOLD] = |(hold_r & sel_vec);
      ctrl_view[ttc_pkg::TTC_POS_REL] = |(rel_r & sel_vec);
   end

   always_comb begin
      rd_nxt = '0;
      err_nxt = 1'b0;
      unique case (paddr_i)
         ttc_pkg::TTC_OFS_CTRL: rd_nxt = ctrl_view;
         ttc_pkg::TTC_OFS_STAT1: rd_nxt = pick(st1_r, sel_vec);
         ttc_pkg::TTC_OFS_STAT2: rd_nxt = pick(st2_r, sel_vec);
         ttc_pkg::TTC_OFS_STAT3: rd_nxt = pick(st3_r, sel_vec);
         default: err_nxt = 1'b1;
      endcase
   end

   // read data registered in the setup phase so prdata comes from a flop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_r <= '0;
         err_r <= 1'b0;
      end else if (psel_i && !penable_i) begin
         rd_r <= pwrite_i ? 32'h00000000 : rd_nxt;
         err_r <= err_nxt;
      end
   end

   assign prdata_o = rd_r;
   assign pslverr_o = acc && err_r;
endmodule

// ==== src/ttc_src_flags.sv ====
// Purpose: done, error and retry flags of one transmit source
// Assumes: event inputs are one-cycle pulses from the transmit engine
// Notes: bus reset sets done, clears retry, and clears error unless ERR_KEEP_ON_BUS_RESET
`timescale 1ns/100ps
module ttc_src_flags #(
   parameter bit ERR_KEEP_ON_BUS_RESET = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic bus_reset_i,
   // events
   input wire logic start_i,
   input wire logic end_ok_i,
   input wire logic end_err_i,
   input wire logic abort_i,
   input wire logic retry_start_i,
   input wire logic retry_end_i,
   // flags
   output logic done_o,
   output logic err_o,
   output logic retry_o
);
   logic done_r;
   logic err_r;
   logic retry_r;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_r <= 1'b1;
      end else if (bus_reset_i || end_ok_i || end_err_i || abort_i) begin
         done_r <= 1'b1;
      end else if (start_i) begin
         done_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_r <= 1'b0;
      end else if (end_err_i || abort_i) begin
         err_r <= 1'b1;
      end else if (bus_reset_i && !ERR_KEEP_ON_BUS_RESET) begin
         err_r <= 1'b0;
      end else if (end_ok_i || start_i) begin
         err_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         retry_r <= 1'b0;
      end else if (retry_start_i) begin
         // a new retry beats any clear in the same cycle, so it is never lost
         retry_r <= 1'b1;
      end else if (bus_reset_i || retry_end_i) begin
         retry_r <= 1'b0;
      end
   end

   assign done_o = done_r;
   assign err_o = err_r;
   assign retry_o = retry_r;
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the timer control register block
// Assumes: zero-wait apb slave, engine model answers abort and release
// Notes: ev_v packs all event pulses but the abort and release answers: start, ok, err, retry start, retry end, bus reset
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   localparam logic [31:0] R = ttc_pkg::TTC_CTRL_RESET;
   localparam logic [7:0] CT = ttc_pkg::TTC_OFS_CTRL;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, slow = 1'b0, slv;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, rdat, prdata_o;
   logic [35:0] ev_v = 36'h0;
   logic [15:0] node = 16'h0, upper = 16'h0;
   logic [31:0] olow = 32'h0, info = 32'h0;
   logic pready_o, pslverr_o, bus_reset_i;
   logic [6:0] tx_start_i, tx_end_ok_i, tx_end_err_i, retry_start_i, retry_end_i, m;
   logic [6:0] abort_done_i, release_done_i, abort_req_o, hold_o, release_req_o;
   logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6};
   int slots [5] = '{0, 1, 3, 4, 6};
   int err_count = 0, n_checks = 0, cyc = 0;
   always #10 clk_i = ~clk_i;
   assign {tx_start_i, tx_end_ok_i, tx_end_err_i, retry_start_i, retry_end_i, bus_reset_i} = ev_v;
   ttc_regs ttc_regs_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .bus_reset_i(bus_reset_i), .tx_start_i(tx_start_i), .tx_end_ok_i(tx_end_ok_i),
      .tx_end_err_i(tx_end_err_i), .retry_start_i(retry_start_i), .retry_end_i(retry_end_i),
      .abort_done_i(abort_done_i), .release_done_i(release_done_i), .req_node_id_i(node),
      .req_offset_upper_i(upper), .req_offset_low_i(olow), .req_info_i(info),
      .abort_req_o(abort_req_o), .hold_o(hold_o), .release_req_o(release_req_o));
   ttc_engine_model ttc_engine_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
      .abort_req_i(abort_req_o), .release_req_i(release_req_o),
      .abort_done_o(abort_done_i), .release_done_o(release_done_i));
   task automatic summarize();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one apb transfer; an idle edge first keeps successive drives apart
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n == 50) err_count++;
      rdat = prdata_o;
      slv = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic ev(input logic [35:0] v);
      @(posedge clk_i);
      ev_v <= v;
      @(posedge clk_i);
      ev_v <= 36'h0;
      @(negedge clk_i);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while ((abort_req_o | release_req_o) !== 7'h00 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      `CHK(abort_req_o | release_req_o, 7'h00)
   endtask
   task automatic t_defaults();
      xfer(0, CT, 32'h0);
      `CHK({slv, rdat}, {1'b0, R})
      for (int a = 8'h64; a <= 8'h6C; a += 4) begin
         xfer(0, a[7:0], 32'h0);
         `CHK(rdat, 32'h0)
      end
      xfer(1, CT, 32'h05050501);
      xfer(0, CT, 32'h0);
      `CHK(rdat, R)
      xfer(0, 8'h70, 32'h0);
      `CHK({slv, rdat}, {1'b1, 32'h0})
      $display("t_defaults done");
   endtask
   task automatic t_flags();
      for (int i = 0; i < 7; i++) begin
         if (i != 5) begin
            m = 7'h01 << i;
            ev({m, 29'h0});
            xfer(0, CT, 32'h0);
            `CHK(rdat, R & ~(32'h1 << (31 - i)))
            ev({21'h0, m, 8'h0});
            xfer(0, CT, 32'h0);
            `CHK(rdat, R & ~(32'h1 << (31 - i)) | (32'h1 << (15 - i)))
            ev({14'h0, m, 7'h0, m, 1'b0});
            xfer(0, CT, 32'h0);
            `CHK(rdat, R | (32'h1 << (23 - i)))
            ev({7'h0, m, 22'h0});
            xfer(0, CT, 32'h0);
            `CHK(rdat, R)
         end
      end
      $display("t_flags done");
   endtask
   task automatic t_abort();
      slow <= 1'b1;
      xfer(1, CT, 32'h08);
      `CHK(abort_req_o, 7'h01)
      wait_idle();
      xfer(0, CT, 32'h0);
      `CHK(rdat, R | 32'h00800000)
      slow <= 1'b0;
      xfer(1, CT, 32'h06);
      `CHK({abort_req_o, hold_o}, {7'h01, 7'h00})
      wait_idle();
      $display("t_abort done");
   endtask
   task automatic t_hold_sel();
      for (int k = 0; k < 5; k++) begin
         xfer(1, CT, {24'h0, codes[k], 4'h4});
         `CHK(hold_o[slots[k]], 1'b1)
         xfer(0, CT, 32'h0);
         `CHK(rdat, R | 32'h00800000 | {24'h0, codes[k], 4'h4})
      end
      xfer(1, CT, 32'h22); // hold came first, as software must
      `CHK(release_req_o, 7'h08)
      wait_idle();
      `CHK(hold_o[3], 1'b0)
      xfer(1, CT, 32'h58);
      `CHK(abort_req_o, 7'h00)
      $display("t_hold_sel done");
   endtask
   task automatic t_status();
      @(posedge clk_i);
      node <= 16'hA5C3;
      upper <= 16'h1234;
      olow <= 32'hDEADBEEF;
      info <= 32'h0BADF00D;
      ev({7'h08, 29'h0});
      xfer(1, CT, 32'h20);
      xfer(1, 8'h64, 32'hFFFFFFFF);
      xfer(0, 8'h64, 32'h0);
      `CHK(rdat, 32'hA5C31234)
      xfer(0, 8'h68, 32'h0);
      `CHK(rdat, 32'hDEADBEEF)
      xfer(0, 8'h6C, 32'h0);
      `CHK(rdat, 32'h0BADF00D)
      $display("t_status done");
   endtask
   task automatic t_bus_reset();
      ev({14'h0, 7'h07, 7'h08, 8'h0});
      xfer(1, CT, 32'h44);
      ev(36'h1);
      xfer(0, 8'h64, 32'h0);
      `CHK(rdat, 32'h0)
      `CHK(hold_o, 7'h00)
      xfer(0, CT, 32'h0);
      `CHK(rdat, R | 32'h00C00000)
      xfer(1, CT, 32'h20);
      xfer(0, 8'h64, 32'h0);
      `CHK(rdat, 32'h0)
      $display("t_bus_reset done");
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_defaults();
      t_flags();
      t_abort();
      t_hold_sel();
      t_status();
      t_bus_reset();
      summarize();
   end
endmodule

// ==== test/ttc_engine_model.sv ====
// Purpose: transmit engine stand-in answering abort and release requests
// Assumes: requests are levels held until the matching done pulse
// Notes: slow_i stretches the answer so held requests are exercised
`timescale 1ns/100ps
module ttc_engine_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // requests and answers
   input wire logic slow_i,
   input wire logic [6:0] abort_req_i,
   input wire logic [6:0] release_req_i,
   output logic [6:0] abort_done_o,
   output logic [6:0] release_done_o
);
   logic [3:0] cnt_r;
   logic busy;
   assign busy = (abort_req_i | release_req_i) != 7'h00;
   // one counter serves all slots: every pending abort and release request is answered in the same cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 4'h0;
         abort_done_o <= 7'h00;
         release_done_o <= 7'h00;
      end else if (busy && cnt_r == (slow_i ? 4'h6 : 4'h1)) begin
         cnt_r <= 4'h0;
         abort_done_o <= abort_req_i;
         release_done_o <= release_req_i;
      end else begin
         cnt_r <= (busy && abort_done_o == 7'h00 && release_done_o == 7'h00) ? cnt_r + 4'h1 : 4'h0;
         abort_done_o <= 7'h00;
         release_done_o <= 7'h00;
      end
   end
endmodule

// ==== test/ttc_regs_monitor.sv ====
// Purpose: port-level checks of the timer control register block
// Assumes: apb setup/access phases as the block expects
// Notes: bound to every ttc_regs instance
`timescale 1ns/100ps
module ttc_regs_monitor #(
   parameter int NSRC = ttc_pkg::TTC_NSRC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   // engine side
   input wire logic bus_reset_i,
   input wire logic [NSRC-1:0] tx_start_i,
   input wire logic [NSRC-1:0] release_done_i,
   input wire logic [NSRC-1:0] abort_req_o,
   input wire logic [NSRC-1:0] hold_o,
   input wire logic [NSRC-1:0] release_req_o
);
   logic [NSRC-1:0] rel_pend_r;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rel_pend_r <= '0;
      end else begin
         rel_pend_r <= release_req_o & ~release_done_i;
      end
   end
   sequence s_setup_rd(logic [7:0] a);
      psel_i && !penable_i && !pwrite_i && paddr_i == a;
   endsequence
   sequence s_wr_ctrl;
      psel_i && penable_i && pwrite_i && paddr_i == ttc_pkg::TTC_OFS_CTRL && !bus_reset_i;
   endsequence
   a_ctrl_reserved: assert property (
      s_setup_rd(ttc_pkg::TTC_OFS_CTRL) |=> (prdata_o & 32'h05050501) == 32'h0)
      else $error("reserved control bits read nonzero");
   a_abort_write: assert property (
      s_wr_ctrl ##0 (pwdata_i[7:4] == 4'h0 && pwdata_i[3]) |=> abort_req_o[0])
      else $error("abort write did not reach slot 0");
   a_hold_rel_abort: assert property (
      s_wr_ctrl ##0 (pwdata_i[7:1] == 7'h03) |=> abort_req_o[0] && !hold_o[0])
      else $error("hold with release did not abort");
   a_hold_write: assert property (
      s_wr_ctrl ##0 (pwdata_i[7:1] == 7'h12) |=> hold_o[3])
      else $error("hold on select code 2 missing");
   a_reserved_sel: assert property (
      s_wr_ctrl ##0 (pwdata_i[7:4] == 4'h5 && abort_req_o == '0) |=> abort_req_o == '0)
      else $error("reserved select code acted");
   a_release_holds: assert property (
      !$past(bus_reset_i) |-> (release_req_o & rel_pend_r) == rel_pend_r)
      else $error("release request dropped before done");
   a_status_cleared: assert property (
      bus_reset_i ##1 (tx_start_i == '0) ##1 s_setup_rd(ttc_pkg::TTC_OFS_STAT1)
      |=> prdata_o == 32'h0)
      else $error("status not cleared by bus reset");
   a_bus_reset_ctl: assert property (
      bus_reset_i |=> abort_req_o == '0 && hold_o == '0 && release_req_o == '0)
      else $error("controls survive bus reset");
   a_unmapped_err: assert property (
      psel_i && penable_i |-> pslverr_o == !(paddr_i inside {8'h60, 8'h64, 8'h68, 8'h6C}))
      else $error("slave error wrong for address");
endmodule
bind ttc_regs ttc_regs_monitor #(.NSRC(NSRC)) ttc_regs_monitor_i (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .bus_reset_i(bus_reset_i), .tx_start_i(tx_start_i), .release_done_i(release_done_i),
   .abort_req_o(abort_req_o), .hold_o(hold_o), .release_req_o(release_req_o));
